// ### shared/sba_regs.vh
/*
  constants for the sense byte assembler: apb offsets, field positions,
  reset values, record sizes and format codes.
  assumes byte addresses on a 32-bit apb, one aligned word per register.
*/
`ifndef SBA_REGS_VH
`define SBA_REGS_VH

`define SBA_OFF_CTRL 8'h00
`define SBA_OFF_CODE 8'h04
`define SBA_OFF_BASE_LO 8'h08
`define SBA_OFF_BASE_HI 8'h0c
`define SBA_OFF_DRIVE 8'h10
`define SBA_OFF_CUERR 8'h14
`define SBA_OFF_SYMPTOM 8'h18
`define SBA_OFF_RESTART 8'h1c
`define SBA_OFF_STATUS 8'h20
`define SBA_OFF_SENSE0 8'h40
`define SBA_OFF_SENSE5 8'h54

`define SBA_CTRL_START 0
`define SBA_CTRL_CLEAR 1
`define SBA_CTRL_REFCLR 2

`define SBA_ST_BUSY 0
`define SBA_ST_HOLD 1
`define SBA_ST_SEND 2
`define SBA_ST_REFUSED 3
`define SBA_ST_UCHK 4
`define SBA_ST_IDX_LSB 8

`define SBA_RST_WORD 32'h0000_0000
`define SBA_RST_BYTE 8'h00

`define SBA_SENSE_BYTES 24
`define SBA_LEAD_BYTES 8
`define SBA_LAST_LEAD 5'h07
`define SBA_FIRST_TAIL 5'h08
`define SBA_LAST_BYTE 5'h17

`define SBA_FMT_PROG 4'h0
`define SBA_FMT_DRIVE 4'h1
`define SBA_FMT_CU 4'h2
`define SBA_FMT_SELRST 4'h3

`define SBA_MASK_MON_MODE 8'h77
`define SBA_MASK_CHK_STAT 8'h8d
`define SBA_MASK_CTL_CHK 8'hfc
`define SBA_CC_UNUSED 4'hc

`endif

// ### hdl/sba_lead_gen.v
/*
  leading sense bytes 0..7 built from the sense control block.
  assumes sense bit n is stored at vector bit 7-n; pure combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module sba_lead_gen
(
  input wire [7:0] sense_code,
  input wire [7:0] fmt_msg,
  input wire [31:0] base_lo,
  input wire [23:0] base_hi,
  input wire [7:0] restart_code,
  output reg [63:0] lead
);
  reg [7:0] extra;
  reg [1:0] target;
  always @*
  begin
    extra = 8'h00;
    target = {sense_code[4], sense_code[3]};
    extra[3'h7 - sense_code[2:0]] = 1'b1;
    lead[31:0] = base_lo;
    lead[55:32] = base_hi;
    if (sense_code[7])
      lead[9] = 1'b1;
    if (sense_code[6])
    begin
      lead[8] = 1'b1;
      lead[31:24] = restart_code;
    end
    if (sense_code[5])
      lead[22] = 1'b1;
    case (target)
      2'b01: lead[7:0] = lead[7:0] | extra;
      2'b10: lead[15:8] = lead[15:8] | extra;
      2'b11: lead[23:16] = lead[23:16] | extra;
      default: lead[7:0] = lead[7:0];
    endcase
    lead[63:56] = fmt_msg;
  end
endmodule // sba_lead_gen
`default_nettype wire

// ### hdl/sba_top.v
/*
  sense byte assembler: apb register file, 24-byte sense buffer, assembly
  sequencer and byte stream to the channel on a sense command.
  assumes a synchronous channel side that pulses sense_cmd and acks bytes.
*/
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sba_regs.vh"
module sba_top
#(
  parameter ADDR_W = 8,
  parameter NBYTES = `SBA_SENSE_BYTES
)
(
  input wire sys_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sel_reset,
  input wire sense_cmd,
  input wire sense_ack,
  output reg [7:0] sense_data,
  output reg sense_valid,
  output reg sense_done,
  output reg unit_check
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_LEAD = 5'b00010;
  localparam ST_TAIL = 5'b00100;
  localparam ST_HOLD = 5'b01000;
  localparam ST_SEND = 5'b10000;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [4:0] asm_idx_reg;
  reg [4:0] send_idx_reg;
  reg [7:0] sense_mem [0:NBYTES-1];
  reg [7:0] code_reg;
  reg [7:0] fmt_reg;
  reg [31:0] base_lo_reg;
  reg [23:0] base_hi_reg;
  reg [31:0] drive_reg;
  reg [31:0] cuerr_reg;
  reg [19:0] symptom_reg;
  reg [7:0] restart_reg;
  reg refused_reg;
  reg [31:0] rdata_next;
  reg map_hit;
  wire [63:0] lead_bytes;
  wire apb_setup;
  wire apb_done;
  wire wr_ctrl;
  wire start_req;
  wire clear_req;
  wire byte_taken;
  integer k;

  assign apb_setup = psel & ~penable;
  assign apb_done = psel & penable & pready;
  assign wr_ctrl = apb_done & pwrite & (paddr == `SBA_OFF_CTRL);
  assign start_req = wr_ctrl & pwdata[`SBA_CTRL_START];
  assign clear_req = sel_reset | (wr_ctrl & pwdata[`SBA_CTRL_CLEAR]);
  assign byte_taken = sense_valid & sense_ack;

  // leading bytes from the control block
  sba_lead_gen u_lead
  (
    .sense_code(code_reg),
    .fmt_msg(fmt_reg),
    .base_lo(base_lo_reg),
    .base_hi(base_hi_reg),
    .restart_code(restart_reg),
    .lead(lead_bytes)
  );

  // tail byte per format; unlisted formats read zero
  function [7:0] tail_byte;
    input [4:0] idx;
    input [3:0] fmt;
    input [31:0] drv;
    input [31:0] cue;
    input [19:0] sym;
    begin
      tail_byte = 8'h00;
      if (fmt == `SBA_FMT_DRIVE)
      begin
        case (idx)
          5'h08: tail_byte = drv[7:0];
          5'h09: tail_byte = drv[15:8] & `SBA_MASK_MON_MODE;
          5'h0a: tail_byte = drv[23:16];
          5'h0b: tail_byte = drv[31:24] & `SBA_MASK_CHK_STAT;
          5'h16: tail_byte = sym[15:8];
          5'h17: tail_byte = sym[7:0];
          default: tail_byte = 8'h00;
        endcase
      end
      else if (fmt == `SBA_FMT_CU || fmt == `SBA_FMT_SELRST)
      begin
        case (idx)
          5'h08: tail_byte = (fmt == `SBA_FMT_CU) ? (cue[7:0] & `SBA_MASK_CTL_CHK) : cue[7:0];
          5'h09: tail_byte = cue[15:8];
          5'h0a: tail_byte = cue[23:16];
          5'h0b: tail_byte = cue[31:24];
          // unused check codes are dropped rather than reported
          5'h0c: tail_byte = (fmt == `SBA_FMT_CU && sym[19:16] < `SBA_CC_UNUSED) ? {sym[19:16], 4'h0} : 8'h00;
          5'h16: tail_byte = sym[15:8];
          5'h17: tail_byte = sym[7:0];
          default: tail_byte = 8'h00;
        endcase
      end
    end
  endfunction

  // sequencer
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (sense_cmd)
          state_next = ST_SEND;
        else if (start_req)
          state_next = ST_LEAD;
      end
      ST_LEAD:
      begin
        if (asm_idx_reg == `SBA_LAST_LEAD)
          state_next = ST_TAIL;
      end
      ST_TAIL:
      begin
        if (asm_idx_reg == `SBA_LAST_BYTE)
          state_next = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (sense_cmd)
          state_next = ST_SEND;
      end
      ST_SEND:
      begin
        if (byte_taken && send_idx_reg == `SBA_LAST_BYTE)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (clear_req)
      state_next = ST_IDLE;
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      asm_idx_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE)
        asm_idx_reg <= 5'h00;
      else if (state_reg == ST_LEAD || state_reg == ST_TAIL)
        asm_idx_reg <= asm_idx_reg + 5'h01;
    end
  end

  // buffer only moves during assembly or clear
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (k = 0; k < NBYTES; k = k + 1)
        sense_mem[k] <= `SBA_RST_BYTE;
    end
    else if (clear_req)
    begin
      for (k = 0; k < NBYTES; k = k + 1)
        sense_mem[k] <= `SBA_RST_BYTE;
    end
    else if (state_reg == ST_LEAD)
      sense_mem[asm_idx_reg] <= lead_bytes[{asm_idx_reg[2:0], 3'b000} +: 8];
    else if (state_reg == ST_TAIL)
      sense_mem[asm_idx_reg] <= tail_byte(asm_idx_reg, fmt_reg[7:4], drive_reg, cuerr_reg, symptom_reg);
  end

  // channel byte stream
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      send_idx_reg <= 5'h00;
      sense_data <= `SBA_RST_BYTE;
      sense_valid <= 1'b0;
      sense_done <= 1'b0;
      unit_check <= 1'b0;
    end
    else
    begin
      sense_done <= 1'b0;
      if (clear_req)
      begin
        sense_valid <= 1'b0;
        send_idx_reg <= 5'h00;
        unit_check <= 1'b0;
      end
      else if (state_reg != ST_SEND && state_next == ST_SEND)
      begin
        send_idx_reg <= 5'h00;
        sense_data <= sense_mem[0];
        sense_valid <= 1'b1;
      end
      else if (byte_taken)
      begin
        if (send_idx_reg == `SBA_LAST_BYTE)
        begin
          sense_valid <= 1'b0;
          sense_done <= 1'b1;
          unit_check <= 1'b0;
          send_idx_reg <= 5'h00;
        end
        else
        begin
          send_idx_reg <= send_idx_reg + 5'h01;
          sense_data <= sense_mem[send_idx_reg + 5'h01];
        end
      end
      else if (state_reg == ST_TAIL && state_next == ST_HOLD)
        unit_check <= 1'b1;
    end
  end

  // software registers
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      code_reg <= `SBA_RST_BYTE;
      fmt_reg <= `SBA_RST_BYTE;
      base_lo_reg <= `SBA_RST_WORD;
      base_hi_reg <= 24'h00_0000;
      drive_reg <= `SBA_RST_WORD;
      cuerr_reg <= `SBA_RST_WORD;
      symptom_reg <= 20'h0_0000;
      restart_reg <= `SBA_RST_BYTE;
      refused_reg <= 1'b0;
    end
    else
    begin
      // held inputs during assembly keep a record self-consistent
      if (apb_done && pwrite && !(state_reg == ST_LEAD || state_reg == ST_TAIL))
      begin
        case (paddr)
          `SBA_OFF_CODE:
          begin
            code_reg <= pwdata[7:0];
            fmt_reg <= pwdata[15:8];
          end
          `SBA_OFF_BASE_LO: base_lo_reg <= pwdata;
          `SBA_OFF_BASE_HI: base_hi_reg <= pwdata[23:0];
          `SBA_OFF_DRIVE: drive_reg <= pwdata;
          `SBA_OFF_CUERR: cuerr_reg <= pwdata;
          `SBA_OFF_SYMPTOM: symptom_reg <= pwdata[19:0];
          `SBA_OFF_RESTART: restart_reg <= pwdata[7:0];
          default: restart_reg <= restart_reg;
        endcase
      end
      // a refused start sets the flag even in the clearing cycle
      if (start_req && state_reg != ST_IDLE)
        refused_reg <= 1'b1;
      else if (wr_ctrl && pwdata[`SBA_CTRL_REFCLR])
        refused_reg <= 1'b0;
    end
  end

  // read mux, registered with one wait state
  always @*
  begin
    rdata_next = `SBA_RST_WORD;
    map_hit = 1'b1;
    case (paddr)
      `SBA_OFF_CTRL: rdata_next = `SBA_RST_WORD;
      `SBA_OFF_CODE: rdata_next = {16'h0000, fmt_reg, code_reg};
      `SBA_OFF_BASE_LO: rdata_next = base_lo_reg;
      `SBA_OFF_BASE_HI: rdata_next = {8'h00, base_hi_reg};
      `SBA_OFF_DRIVE: rdata_next = drive_reg;
      `SBA_OFF_CUERR: rdata_next = cuerr_reg;
      `SBA_OFF_SYMPTOM: rdata_next = {12'h000, symptom_reg};
      `SBA_OFF_RESTART: rdata_next = {24'h00_0000, restart_reg};
      `SBA_OFF_STATUS:
      begin
        rdata_next[`SBA_ST_BUSY] = state_reg[1] | state_reg[2];
        rdata_next[`SBA_ST_HOLD] = state_reg[3];
        rdata_next[`SBA_ST_SEND] = state_reg[4];
        rdata_next[`SBA_ST_REFUSED] = refused_reg;
        rdata_next[`SBA_ST_UCHK] = unit_check;
        rdata_next[`SBA_ST_IDX_LSB +: 5] = send_idx_reg;
      end
      default:
      begin
        if (paddr >= `SBA_OFF_SENSE0 && paddr <= `SBA_OFF_SENSE5 && paddr[1:0] == 2'b00)
          rdata_next = {sense_mem[{paddr[4:2], 2'b11}], sense_mem[{paddr[4:2], 2'b10}],
                        sense_mem[{paddr[4:2], 2'b01}], sense_mem[{paddr[4:2], 2'b00}]};
        else
          map_hit = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `SBA_RST_WORD;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready)
      begin
        prdata <= pwrite ? `SBA_RST_WORD : rdata_next;
        pslverr <= ~map_hit;
      end
      else if (!psel || apb_setup)
      begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule // sba_top
`default_nettype wire

// ### test/sba_chk.sv
/*
  assertions on the sba_top ports: apb wait state, sense stream, assembly.
  assumes a bind into sba_top, one clock, rstn active low.
*/
`timescale 1ns/1ps
`default_nettype none
module sba_chk
#(
  parameter ADDR_W = 8,
  parameter NBYTES = 24
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sel_reset,
  input wire logic sense_cmd,
  input wire logic sense_ack,
  input wire logic [7:0] sense_data,
  input wire logic sense_valid,
  input wire logic sense_done,
  input wire logic unit_check
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic [4:0] taken_reg;
  logic [4:0] asm_reg;
  wire ctl_wr = pready && pwrite && !pslverr && paddr == '0;
  // asm_reg only arms on an accepted start, refused ones leave it alone
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      taken_reg <= 5'h00;
      asm_reg <= 5'h00;
    end
    else
    begin
      if (sense_done || sel_reset)
        taken_reg <= 5'h00;
      else if (sense_valid && sense_ack)
        taken_reg <= taken_reg + 5'h01;
      if (sel_reset || (ctl_wr && pwdata[1]))
        asm_reg <= 5'h00;
      else if (ctl_wr && pwdata[0] && asm_reg == 5'h00 && !unit_check && !sense_valid)
        asm_reg <= 5'h19;
      else if (asm_reg != 5'h00)
        asm_reg <= asm_reg - 5'h01;
    end
  end
  a_record_len: assert property (sense_done |-> taken_reg == NBYTES)
    else $error("sense record length wrong");
  a_done_end: assert property (sense_done |-> !sense_valid && !unit_check ##1 !sense_done)
    else $error("record end wrong");
  a_first_byte: assert property (sense_cmd && unit_check && !sense_valid && !sel_reset |=> sense_valid)
    else $error("no byte after sense command");
  a_byte_stands: assert property (sense_valid && !sense_ack && !sel_reset |=> sense_valid && $stable(sense_data))
    else $error("byte changed before ack");
  a_check_kept: assert property (unit_check && !sense_valid && !sel_reset && !ctl_wr |=> unit_check)
    else $error("record dropped unsent");
  a_sel_clear: assert property (sel_reset |=> !unit_check && !sense_valid)
    else $error("selective reset not clearing");
  a_asm_time: assert property (asm_reg == 5'h01 && !sel_reset |-> ##[1:2] unit_check)
    else $error("assembly late");
  a_asm_early: assert property (asm_reg > 5'h02 |-> !unit_check)
    else $error("assembly early");
  a_apb_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
endmodule // sba_chk
bind sba_top sba_chk #(.ADDR_W(ADDR_W), .NBYTES(NBYTES)) i_chk (.sys_clk, .rstn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .sel_reset, .sense_cmd, .sense_ack, .sense_data, .sense_valid,
  .sense_done, .unit_check);
`default_nettype wire

// ### test/sba_chan_model.sv
/*
  channel side model: pulses sense commands, acks and keeps the bytes.
  assumes the sba_top channel timing, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sba_chan_model
(
  input wire logic sys_clk,
  input wire logic sense_valid,
  input wire logic [7:0] sense_data,
  input wire logic sense_done,
  output logic sense_cmd,
  output logic sense_ack
);
  logic [7:0] got [0:23];
  int n;
  logic fin;
  logic slow;
  initial
  begin
    sense_cmd = 1'b0;
    sense_ack = 1'b0;
    n = 0;
    fin = 1'b0;
    slow = 1'b0;
  end
  // slow mode acks every other cycle so each byte must stand
  always @(posedge sys_clk)
  begin
    if (sense_valid && sense_ack)
    begin
      got[n] <= sense_data;
      n <= n + 1;
    end
    sense_ack <= sense_valid && !(slow && sense_ack);
    if (sense_done)
      fin <= 1'b1;
  end
  task sense;
  begin
    n = 0;
    fin = 1'b0;
    sense_cmd <= 1'b1;
    @(posedge sys_clk);
    sense_cmd <= 1'b0;
  end
  endtask
endmodule // sba_chan_model
`default_nettype wire

// ### test/testbench.sv
/*
  bench for sba_top: apb master tasks, channel model, a task per scenario.
  assumes sba_regs.vh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sba_regs.vh"
`define CHK(s, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", s, e, g); end end
module testbench;
  logic sys_clk, rstn, psel, penable, pwrite, sel_reset;
  logic [7:0] paddr, code, fm, rcode;
  logic [31:0] pwdata, rd, blo, drv, cue;
  logic [23:0] bhi;
  logic [19:0] sym;
  wire [31:0] prdata;
  wire [7:0] sense_data;
  wire pready, pslverr, sense_valid, sense_done, unit_check, sense_cmd, sense_ack;
  int n_errors, tests_run;
  sba_top i_dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sel_reset, .sense_cmd, .sense_ack, .sense_data, .sense_valid, .sense_done, .unit_check);
  sba_chan_model i_chan (.sys_clk, .sense_valid, .sense_data, .sense_done, .sense_cmd, .sense_ack);
  function automatic logic [7:0] ex(input int i);
    logic [7:0] b;
    b = 8'h00;
    if (i < 4)
      b = blo[8*i+:8];
    else if (i < 7)
      b = bhi[8*(i-4)+:8];
    else if (i == 7)
      b = fm;
    if (i == 1)
      b = b | {6'h00, code[7], code[6]};
    if (i == 2)
      b[6] = b[6] | code[5];
    if (i == 3 && code[6])
      b = rcode;
    if (code[4:3] != 2'b00 && i == code[4:3] - 1)
      b[7 - code[2:0]] = 1'b1;
    if (i >= 8 && i < 12 && fm[7:4] == 4'h1)
      b = drv[8*(i-8)+:8] & (i == 9 ? 8'h77 : i == 11 ? 8'h8d : 8'hff);
    if (i >= 8 && i < 12 && fm[7:4] inside {4'h2, 4'h3})
      b = cue[8*(i-8)+:8] & (i == 8 && fm[7:4] == 4'h2 ? 8'hfc : 8'hff);
    if (i == 12 && fm[7:4] == 4'h2 && sym[19:16] < 4'hc)
      b = {sym[19:16], 4'h0};
    if (i >= 22 && fm[7:4] inside {4'h1, 4'h2, 4'h3})
      b = i == 22 ? sym[15:8] : sym[7:0];
    return b;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 9);
    rd = prdata;
    `CHK("apb resp", {1'b1, e}, {pready, pslverr})
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task wait_uc;
    int k;
    k = 0;
    while (unit_check !== 1'b1 && k < 60)
    begin
      @(posedge sys_clk);
      k++;
    end
    `CHK("unit_check", 1'b1, unit_check)
  endtask
  task sense_chk;
    int k;
    i_chan.sense();
    k = 0;
    while (i_chan.fin !== 1'b1 && k < 200)
    begin
      @(posedge sys_clk);
      k++;
    end
    `CHK("count", 24, i_chan.n)
    for (int i = 0; i < 24; i++)
      `CHK("byte", ex(i), i_chan.got[i])
    `CHK("unit_check", 1'b0, unit_check)
  endtask
  task run;
    wr(`SBA_OFF_CODE, {16'h0000, fm, code});
    wr(`SBA_OFF_BASE_LO, blo);
    wr(`SBA_OFF_BASE_HI, {8'h00, bhi});
    wr(`SBA_OFF_DRIVE, drv);
    wr(`SBA_OFF_CUERR, cue);
    wr(`SBA_OFF_SYMPTOM, {12'h000, sym});
    wr(`SBA_OFF_RESTART, {24'h000000, rcode});
    wr(`SBA_OFF_CTRL, 32'h0000_0001);
    wait_uc;
    sense_chk;
  endtask
  task t_reset;
    apb(1'b0, `SBA_OFF_STATUS, 32'h0000_0000, 1'b0);
    `CHK("status", 32'h0000_0000, rd)
    apb(1'b0, `SBA_OFF_SENSE5, 32'h0000_0000, 1'b0);
    `CHK("sense5", 32'h0000_0000, rd)
    apb(1'b0, 8'h30, 32'h0000_0000, 1'b1);
    `CHK("unmapped", 32'h0000_0000, rd)
  endtask
  task t_code;
    blo = 32'h9911_2233;
    bhi = 24'h66_5544;
    drv = 32'hc3a5_5a3c;
    cue = 32'h96e1_1e69;
    sym = 20'h9_beef;
    rcode = 8'h27;
    fm = 8'h0c;
    for (int s = 0; s < 8; s++)
    begin
      code = {s[2:0], s[1:0], 3'(7 - s)};
      run;
    end
  endtask
  task t_fmt;
    code = 8'h00;
    for (int f = 1; f < 6; f++)
    begin
      fm = {f == 5 ? 4'h2 : 4'(f), 4'(f + 7)};
      sym = {f == 5 ? 4'hc : 4'h9, 16'hbeef};
      run;
    end
  endtask
  // code write and second start land mid-assembly, both must be ignored
  task t_hold;
    fm = 8'h13;
    code = 8'he0;
    run;
    i_chan.slow = 1'b1;
    sense_chk;
    i_chan.slow = 1'b0;
    wr(`SBA_OFF_CTRL, 32'h0000_0001);
    wr(`SBA_OFF_CODE, 32'h0000_0000);
    wr(`SBA_OFF_CTRL, 32'h0000_0001);
    wait_uc;
    apb(1'b0, `SBA_OFF_STATUS, 32'h0000_0000, 1'b0);
    `CHK("status", 5'h1a, rd[4:0])
    sense_chk;
    wr(`SBA_OFF_CTRL, 32'h0000_0004);
    apb(1'b0, `SBA_OFF_STATUS, 32'h0000_0000, 1'b0);
    `CHK("refused", 1'b0, rd[3])
  endtask
  task t_sel;
    wr(`SBA_OFF_CTRL, 32'h0000_0001);
    wait_uc;
    wr(`SBA_OFF_CTRL, 32'h0000_0002);
    apb(1'b0, `SBA_OFF_STATUS, 32'h0000_0000, 1'b0);
    `CHK("status", 32'h0000_0000, rd)
    apb(1'b0, `SBA_OFF_SENSE0, 32'h0000_0000, 1'b0);
    `CHK("sense0", 32'h0000_0000, rd)
    wr(`SBA_OFF_CTRL, 32'h0000_0001);
    wait_uc;
    sel_reset <= 1'b1;
    @(posedge sys_clk);
    sel_reset <= 1'b0;
    @(posedge sys_clk);
    `CHK("unit_check", 1'b0, unit_check)
    code = 8'h00;
    fm = 8'h00;
    blo = 32'h0000_0000;
    bhi = 24'h00_0000;
    sense_chk;
  endtask
  task summarize;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    #1000000;
    n_errors++;
    summarize;
  end
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sel_reset = 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_code;
    t_fmt;
    t_hold;
    t_sel;
    summarize;
  end
endmodule // testbench
`default_nettype wire
